// File: rtl/dlar_pkg.sv
// dlar_pkg: offsets, field layout and default values of the descriptor length attribute registers
// assumes an APB slave with 32-bit data and byte addressing
package dlar_pkg;
    localparam logic [7:0] DLAR_OFF_EEDATA = 8'h44;
    localparam logic [7:0] DLAR_OFF_BOS = 8'h50;
    localparam logic [7:0] DLAR_OFF_SS = 8'h54;
    localparam logic [7:0] DLAR_OFF_HS = 8'h58;
    localparam logic [7:0] DLAR_OFF_CTRL = 8'h5C;
    localparam logic [7:0] DLAR_OFF_STAT = 8'h60;
    localparam int DLAR_ADDR_W = 8;
    localparam int DLAR_POLL_LSB = 16;
    localparam int DLAR_DEV_LSB = 8;
    localparam int DLAR_CFG_LSB = 0;
    localparam int DLAR_CTRL_EMUL_BIT = 0;
    localparam int DLAR_STAT_EE_BIT = 0;
    localparam int DLAR_STAT_OTP_BIT = 1;
    localparam int DLAR_STAT_ACT_BIT = 2;
    localparam int DLAR_STAT_BUSY_BIT = 3;
    localparam logic [7:0] DLAR_SS_POLL_DEF = 8'h06;
    localparam logic [7:0] DLAR_HS_POLL_DEF = 8'h04;
    localparam logic [7:0] DLAR_LEN_DEF = 8'h00;
    localparam logic [7:0] DLAR_SS_LEN_LEGAL = 8'h12;
    localparam logic [2:0] DLAR_CMD_READ = 3'h0;
    localparam logic [2:0] DLAR_CMD_WRITE = 3'h3;
    localparam logic [31:0] DLAR_ZERO = 32'h0000_0000;
endpackage : dlar_pkg

// File: rtl/dlar_regs.sv
// dlar_regs: eeprom data byte and descriptor length attribute registers on APB
// assumes an eeprom engine outside that pulses done with read data, and image
// values from eeprom or otp held stable by their loaders
// Function
// R1: eeprom data register holds low byte only
// R2: read fetches byte, write sends byte out
// R3: bos length field eight bits, read/write
// R4: software keeps valid bos block contents
// R5: bos default eeprom, otp, else zero
// R6: software writes zero for absent descriptors
// R7: attributes apply only when emulation active
// R8: software avoids writes with eeprom/otp present
// R9: attribute registers obey reset protection
// R10: superspeed poll, device, config fields
// R11: superspeed config then interface order
// R12: nonzero superspeed lengths used as 12h
// R13: superspeed poll default eeprom, otp, 06h
// R14: superspeed lengths default eeprom, otp, zero
// R15: highspeed poll, device, config fields
// R16: software writes highspeed lengths 0 or 12h
// R17: highspeed poll default eeprom, otp, 04h
// R18: highspeed lengths default eeprom, otp, zero
// R19: reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
module dlar_regs (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eepromPresent,
    input wire logic otpConfigured,
    input wire logic [7:0] eeBosLen,
    input wire logic [23:0] eeSsAttr,
    input wire logic [23:0] eeHsAttr,
    input wire logic [7:0] otpBosLen,
    input wire logic [23:0] otpSsAttr,
    input wire logic [23:0] otpHsAttr,
    input wire logic usbReset,
    input wire logic lite_soft_reset,
    input wire logic resetProtect,
    input wire logic [2:0] eepromCmd,
    input wire logic eepromCmdStart,
    input wire logic eepromCmdDone,
    input wire logic [7:0] eepromRdByte,
    output logic [7:0] eepromWrByte,
    output logic attrActive,
    output logic [7:0] bosLenEff,
    output logic [7:0] ssPollEff,
    output logic [7:0] ssDevLenEff,
    output logic [7:0] ssCfgLenEff,
    output logic [7:0] hsPollEff,
    output logic [7:0] hsDevLenEff,
    output logic [7:0] hsCfgLenEff
);
    logic [7:0] eeData_r, eeData_nxt;
    logic [7:0] bos_r, bos_nxt;
    logic [23:0] ss_r, ss_nxt;
    logic [23:0] hs_r, hs_nxt;
    logic emul_r, emul_nxt;
    logic busy_r, busy_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic [7:0] bosDef;
    logic [23:0] ssDef, hsDef;
    logic wrEn, rdEn, restore;
    logic [7:0] addr;

    // byte-lane merge of a write into an existing field
    function automatic logic [31:0] dlar_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction

    // nonzero superspeed length counts as the one legal size
    function automatic logic [7:0] dlar_ss_len(input logic [7:0] v);
        return (v != dlar_pkg::DLAR_LEN_DEF) ? dlar_pkg::DLAR_SS_LEN_LEGAL : dlar_pkg::DLAR_LEN_DEF;
    endfunction

    assign addr = paddr[7:0];
    assign pready = 1'b1;
    // unmapped addresses answer with an error; high address bits must be zero
    assign pslverr = psel && penable && ((paddr[31:8] != 24'h000000) || !(addr == dlar_pkg::DLAR_OFF_EEDATA ||
        addr == dlar_pkg::DLAR_OFF_BOS || addr == dlar_pkg::DLAR_OFF_SS || addr == dlar_pkg::DLAR_OFF_HS ||
        addr == dlar_pkg::DLAR_OFF_CTRL || addr == dlar_pkg::DLAR_OFF_STAT));
    assign wrEn = psel && penable && pwrite && !pslverr;
    assign rdEn = psel && penable && !pwrite;

    // defaults pick eeprom image, else otp image, else fixed values
    always_comb
    begin
        if (eepromPresent)
        begin
            bosDef = eeBosLen; // [R5]
            ssDef = eeSsAttr; // [R13] [R14]
            hsDef = eeHsAttr; // [R17] [R18]
        end
        else if (otpConfigured)
        begin
            bosDef = otpBosLen; // [R5]
            ssDef = otpSsAttr; // [R13] [R14]
            hsDef = otpHsAttr; // [R17] [R18]
        end
        else
        begin
            bosDef = dlar_pkg::DLAR_LEN_DEF; // [R5]
            ssDef = {dlar_pkg::DLAR_SS_POLL_DEF, dlar_pkg::DLAR_LEN_DEF, dlar_pkg::DLAR_LEN_DEF}; // [R13] [R14]
            hsDef = {dlar_pkg::DLAR_HS_POLL_DEF, dlar_pkg::DLAR_LEN_DEF, dlar_pkg::DLAR_LEN_DEF}; // [R17] [R18]
        end
    end

    // reset protection keeps software values across usb and lite resets
    assign restore = (usbReset || lite_soft_reset) && !resetProtect; // [R9]

    always_comb
    begin
        logic [31:0] m;
        m = dlar_pkg::DLAR_ZERO;
        eeData_nxt = eeData_r;
        bos_nxt = bos_r;
        ss_nxt = ss_r;
        hs_nxt = hs_r;
        emul_nxt = emul_r;
        busy_nxt = busy_r;
        cmd_nxt = cmd_r;
        if (wrEn)
        begin
            unique case (addr)
                dlar_pkg::DLAR_OFF_EEDATA: if (pstrb[0]) eeData_nxt = pwdata[7:0]; // [R1]
                dlar_pkg::DLAR_OFF_BOS:
                begin
                    m = dlar_merge({24'h000000, bos_r}, pwdata, pstrb);
                    bos_nxt = m[7:0]; // [R3] [R19]
                end
                dlar_pkg::DLAR_OFF_SS:
                begin
                    m = dlar_merge({8'h00, ss_r}, pwdata, pstrb);
                    ss_nxt = m[23:0]; // [R10] [R19]
                end
                dlar_pkg::DLAR_OFF_HS:
                begin
                    m = dlar_merge({8'h00, hs_r}, pwdata, pstrb);
                    hs_nxt = m[23:0]; // [R15] [R19]
                end
                dlar_pkg::DLAR_OFF_CTRL: if (pstrb[0]) emul_nxt = pwdata[dlar_pkg::DLAR_CTRL_EMUL_BIT];
                default: ;
            endcase
        end
        if (restore)
        begin
            bos_nxt = bosDef; // [R5]
            ss_nxt = ssDef; // [R13] [R14]
            hs_nxt = hsDef; // [R17] [R18]
        end
        if (eepromCmdStart)
        begin
            busy_nxt = 1'b1;
            cmd_nxt = eepromCmd;
        end
        // completion of a read loads the fetched byte; the engine owns the register then
        if (busy_r && eepromCmdDone)
        begin
            busy_nxt = 1'b0;
            if (cmd_r == dlar_pkg::DLAR_CMD_READ)
                eeData_nxt = eepromRdByte; // [R2]
        end
    end

    // power-on values are the fixed defaults; images are loaded by the first restore
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            eeData_r <= dlar_pkg::DLAR_LEN_DEF;
            bos_r <= dlar_pkg::DLAR_LEN_DEF;
            ss_r <= {dlar_pkg::DLAR_SS_POLL_DEF, dlar_pkg::DLAR_LEN_DEF, dlar_pkg::DLAR_LEN_DEF};
            hs_r <= {dlar_pkg::DLAR_HS_POLL_DEF, dlar_pkg::DLAR_LEN_DEF, dlar_pkg::DLAR_LEN_DEF};
            emul_r <= 1'b0;
            busy_r <= 1'b0;
            cmd_r <= dlar_pkg::DLAR_CMD_READ;
        end
        else
        begin
            eeData_r <= eeData_nxt;
            bos_r <= bos_nxt;
            ss_r <= ss_nxt;
            hs_r <= hs_nxt;
            emul_r <= emul_nxt;
            busy_r <= busy_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    // write commands store the held byte at the selected location
    assign eepromWrByte = eeData_r; // [R2]
    assign attrActive = !eepromPresent && !otpConfigured && emul_r; // [R7]
    assign bosLenEff = attrActive ? bos_r : dlar_pkg::DLAR_LEN_DEF; // [R7]
    assign ssPollEff = attrActive ? ss_r[dlar_pkg::DLAR_POLL_LSB +: 8] : dlar_pkg::DLAR_LEN_DEF;
    assign ssDevLenEff = attrActive ? dlar_ss_len(ss_r[dlar_pkg::DLAR_DEV_LSB +: 8]) : dlar_pkg::DLAR_LEN_DEF; // [R12]
    assign ssCfgLenEff = attrActive ? dlar_ss_len(ss_r[dlar_pkg::DLAR_CFG_LSB +: 8]) : dlar_pkg::DLAR_LEN_DEF; // [R12]
    assign hsPollEff = attrActive ? hs_r[dlar_pkg::DLAR_POLL_LSB +: 8] : dlar_pkg::DLAR_LEN_DEF;
    assign hsDevLenEff = attrActive ? hs_r[dlar_pkg::DLAR_DEV_LSB +: 8] : dlar_pkg::DLAR_LEN_DEF;
    assign hsCfgLenEff = attrActive ? hs_r[dlar_pkg::DLAR_CFG_LSB +: 8] : dlar_pkg::DLAR_LEN_DEF;

    // read mux; reserved bits are zero
    always_comb
    begin
        prdata = dlar_pkg::DLAR_ZERO;
        if (rdEn)
        begin
            unique case (addr)
                dlar_pkg::DLAR_OFF_EEDATA: prdata = {24'h000000, eeData_r}; // [R1] [R19]
                dlar_pkg::DLAR_OFF_BOS: prdata = {24'h000000, bos_r}; // [R3] [R19]
                dlar_pkg::DLAR_OFF_SS: prdata = {8'h00, ss_r}; // [R10] [R19]
                dlar_pkg::DLAR_OFF_HS: prdata = {8'h00, hs_r}; // [R15] [R19]
                dlar_pkg::DLAR_OFF_CTRL: prdata = {31'h00000000, emul_r};
                dlar_pkg::DLAR_OFF_STAT: prdata = {28'h0000000, busy_r, attrActive, otpConfigured, eepromPresent};
                default: prdata = dlar_pkg::DLAR_ZERO;
            endcase
        end
    end
endmodule // dlar_regs
`default_nettype wire

// File: sim/dlar_properties.sv
// checker: apb answer and effective-value properties of dlar_regs
// assumes bind to dlar_regs; watches a subset of its ports
`timescale 1ns/100ps
`default_nettype none
module dlar_properties (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic eepromPresent,
    input wire logic otpConfigured,
    input wire logic usbReset,
    input wire logic resetProtect,
    input wire logic eepromCmdDone,
    input wire logic [7:0] eepromWrByte,
    input wire logic attrActive,
    input wire logic [7:0] bosLenEff,
    input wire logic [7:0] ssPollEff,
    input wire logic [7:0] ssDevLenEff,
    input wire logic [7:0] hsPollEff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic rdAcc = psel && penable && !pwrite && pready;
    wire logic [7:0] wrLow = pwdata[7:0];
    active_cause_a: assert property (attrActive |-> !eepromPresent && !otpConfigured)
        else $error("attributes active with an image present");
    eff_idle_a: assert property (!attrActive |-> bosLenEff == 8'h00 && ssPollEff == 8'h00 && hsPollEff == 8'h00)
        else $error("effective value shown while inactive");
    ss_clamp_a: assert property (ssDevLenEff != 8'h00 |-> ssDevLenEff == 8'h12)
        else $error("superspeed length not shown as 12h");
    ee_reserved_a: assert property (rdAcc && paddr == 32'h44 |-> prdata[31:8] == 24'h0)
        else $error("eeprom data upper bits not zero");
    bos_reserved_a: assert property (rdAcc && paddr == 32'h50 |-> prdata[31:8] == 24'h0)
        else $error("bos upper bits not zero");
    attr_reserved_a: assert property (rdAcc && (paddr == 32'h54 || paddr == 32'h58) |-> prdata[31:24] == 8'h00)
        else $error("attribute top byte not zero");
    wr_byte_a: assert property (psel && penable && pwrite && pready && pstrb[0] && paddr == 32'h44
        && !eepromCmdDone |=> eepromWrByte == $past(wrLow)) else $error("eeprom byte not taken");
    restore_def_a: assert property (usbReset && !resetProtect && !eepromPresent && !otpConfigured
        |=> !attrActive || (ssPollEff == 8'h06 && hsPollEff == 8'h04 && bosLenEff == 8'h00)) else $error("bad restore");
endmodule // dlar_properties
bind dlar_regs dlar_properties prop_u (.*);
`default_nettype wire

// File: sim/testbench.sv
// testbench: register model of dlar_regs driven over apb
// assumes dlar_properties is bound by its own file
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_sys, resetn, psel, penable, pwrite, eepromPresent, otpConfigured, usbReset, lite_soft_reset;
    logic resetProtect, eepromCmdStart, eepromCmdDone, pready, pslverr, attrActive, err;
    logic [31:0] paddr, pwdata, prdata, rd, d, mdl [4];
    logic [3:0] pstrb;
    logic [2:0] eepromCmd;
    logic [7:0] eeBosLen, otpBosLen, eepromRdByte, eepromWrByte, bosLenEff, ssPollEff, ssDevLenEff, ssCfgLenEff;
    logic [7:0] hsPollEff, hsDevLenEff, hsCfgLenEff;
    logic [23:0] eeSsAttr, eeHsAttr, otpSsAttr, otpHsAttr;
    int error_cnt = 0;
    int check_count = 0;
    localparam logic [31:0] ADR [4] = '{32'h44, 32'h50, 32'h54, 32'h58};
    localparam logic [31:0] MSK [4] = '{32'hFF, 32'hFF, 32'hFFFFFF, 32'hFFFFFF};
    dlar_regs dut_u (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // master holds the request until pready is seen high at a rising edge or 50 edges pass
    task automatic apb(input logic wr, input logic [31:0] a, dat);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) error_cnt++;
    endtask
    task automatic wreg(input int i, input logic [31:0] dat);
        apb(1'b1, ADR[i], dat);
        mdl[i] = dat & MSK[i];
    endtask
    task automatic rreg(input int i);
        apb(1'b0, ADR[i], 32'h0);
        chk($sformatf("reg %h", ADR[i]), rd, mdl[i]);
    endtask
    task automatic ecmd(input logic [2:0] c);
        eepromCmd <= c;
        eepromCmdStart <= 1'b1;
        @(posedge clk_sys);
        eepromCmdStart <= 1'b0;
        eepromRdByte <= 8'($urandom());
        @(posedge clk_sys);
        eepromCmdDone <= 1'b1;
        @(posedge clk_sys);
        eepromCmdDone <= 1'b0;
        if (c == 3'h0) mdl[0] = {24'h0, eepromRdByte};
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #200us;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, eepromPresent, otpConfigured, usbReset, lite_soft_reset} = '0;
        {resetProtect, eepromCmd, eepromCmdStart, eepromCmdDone, eepromRdByte} = '0;
        {eeBosLen, eeSsAttr, eeHsAttr, otpBosLen, otpSsAttr, otpHsAttr} = '0;
        pstrb = 4'hF;
        resetn = 1'b0;
        mdl = '{32'h0, 32'h0, 32'h60000, 32'h40000};
        void'($urandom(32'hA6A3));
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++) rreg(i);
        // writes give highspeed length fields only 0 or 12h, superspeed ones also 05h once; no descriptor ram here, so lengths describe no block contents
        // attribute writes happen only with no eeprom and no otp image
        repeat (3)
            for (int i = 0; i < 4; i++)
            begin
                d = $urandom();
                if (i > 1) d = {d[31:16], d[0] ? 16'h1212 : 16'h0};
                wreg(i, d);
                rreg(i);
            end
        apb(1'b0, 32'h48, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1'b1, 32'h5C, 32'h1);
        wreg(2, 32'h00170512);
        @(posedge clk_sys);
        chk("active", {31'h0, attrActive}, 32'h1);
        chk("ss eff", {ssPollEff, ssDevLenEff, ssCfgLenEff}, 32'h171212);
        chk("hs eff", {hsPollEff, hsDevLenEff, hsCfgLenEff}, mdl[3]);
        chk("bos eff", bosLenEff, mdl[1]);
        // source order: eeprom, otp, eeprom under protection, none
        for (int s = 0; s < 4; s++)
        begin
            d = $urandom();
            {eeBosLen, eeSsAttr} <= d;
            {otpBosLen, eeHsAttr} <= {d[7:0], d[31:8]} ^ 32'h5A5A5A5A;
            {otpSsAttr, otpHsAttr} <= {d[23:0], d[31:8]} ^ 48'hC3C3C3C3C3C3;
            eepromPresent <= (s == 0 || s == 2);
            otpConfigured <= (s == 1);
            resetProtect <= (s == 2);
            @(posedge clk_sys);
            usbReset <= s[0];
            lite_soft_reset <= !s[0];
            @(posedge clk_sys);
            {usbReset, lite_soft_reset} <= 2'b00;
            if (s == 0) {mdl[1], mdl[2], mdl[3]} = {24'h0, eeBosLen, 8'h0, eeSsAttr, 8'h0, eeHsAttr};
            if (s == 1) {mdl[1], mdl[2], mdl[3]} = {24'h0, otpBosLen, 8'h0, otpSsAttr, 8'h0, otpHsAttr};
            if (s == 3) {mdl[1], mdl[2], mdl[3]} = {32'h0, 32'h60000, 32'h40000};
            for (int i = 1; i < 4; i++) rreg(i);
        end
        resetProtect <= 1'b0;
        wreg(0, $urandom());
        @(posedge clk_sys);
        chk("eeprom out", eepromWrByte, mdl[0]);
        ecmd(3'h0);
        rreg(0);
        ecmd(3'h3);
        rreg(0);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
